// ### hdl/pulse_timer_counter_capture.sv
// One timer channel with timer, PWM, counter and capture modes behind an APB slave.
`include "ptc_defs.svh"

module pulse_timer_counter_capture #(
	parameter bit HAS_INPUTS = 1'b1,
	parameter int CMP_W      = `PTC_CMP_W
) (
	input  wire logic              i_clk,
	input  wire logic              i_sys_rst,
	input  ptc_pkg::apb_req_t      i_apb,
	output logic                   o_pready,
	output logic [31:0]            o_prdata,
	output logic                   o_pslverr,
	input  wire logic              i_src16_tick,
	input  wire logic              i_src32_tick,
	input  wire logic              i_capture_pin,
	input  wire logic              i_count_pin,
	output logic                   o_timer_out,
	output logic                   o_rise_interrupt,
	output logic                   o_period_interrupt
);

	generate
		if (CMP_W != `PTC_CMP_W) begin : g_bad_width
			$error("CMP_W must equal the 17-bit wide compare path");
		end
	endgenerate

	ptc_pkg::cfg_t     cfg;
	ptc_pkg::state_t   state;
	logic [CMP_W-1:0]  rise_compare_wide;
	logic [CMP_W-1:0]  period_compare_wide;
	logic [CMP_W-1:0]  count;
	logic [CMP_W-1:0]  cap_rise;
	logic [CMP_W-1:0]  cap_fall;
	logic              repeat_run;
	logic              counter_mode;
	logic              cap_meta;
	logic              cap_sync;
	logic              cnt_meta;
	logic              cnt_sync;
	logic              cnt_prev;
	logic              cap_sample;

	logic              apb_setup;
	logic              apb_write;
	logic              addr_known;
	logic              cmd_write;
	logic              start_single;
	logic              start_repeat;
	logic              start_capture;
	logic              stop_cmd;
	logic              any_start;
	logic              src_tick;
	logic              timer_tick;
	logic              edge_event;
	logic              run_event;
	logic              cap_level;
	logic              cap_now;
	logic [CMP_W-1:0]  next_count;
	logic [CMP_W-1:0]  rise_eff;
	logic [CMP_W-1:0]  period_eff;
	logic [31:0]       next_prdata;

	// Narrow mode keeps only the low 16 bits so wraps match the 16 MHz path.
	function automatic logic [CMP_W-1:0] fit_width(
		input logic [CMP_W-1:0] value,
		input logic             wide
	);
		logic [CMP_W-1:0] result;
		result = value;
		if (!wide)
			result[CMP_W-1:`PTC_NARROW_W] = '0;
		return result;
	endfunction

	function automatic logic [31:0] widen(input logic [CMP_W-1:0] value);
		return {{(32 - CMP_W){1'b0}}, value};
	endfunction

	// APB decode.

	assign apb_setup = i_apb.psel && !i_apb.penable;
	assign apb_write = i_apb.psel && i_apb.penable && o_pready && i_apb.pwrite;
	assign cmd_write = apb_write && (i_apb.paddr == `PTC_REG_CMD);

	always_comb begin
		case (i_apb.paddr)
			`PTC_REG_CFG,
			`PTC_REG_CMD,
			`PTC_REG_RISE,
			`PTC_REG_PERIOD,
			`PTC_REG_COUNT,
			`PTC_REG_CAP_RISE,
			`PTC_REG_CAP_FALL,
			`PTC_REG_STATUS: addr_known = 1'b1;
			default:         addr_known = 1'b0;
		endcase
	end

	always_comb begin
		next_prdata = '0;
		case (i_apb.paddr)
			`PTC_REG_CFG:      next_prdata = {21'h000000, cfg};
			`PTC_REG_RISE:     next_prdata = widen(rise_compare_wide);
			`PTC_REG_PERIOD:   next_prdata = widen(period_compare_wide);
			`PTC_REG_COUNT:    next_prdata = widen(count); // [R13]
			`PTC_REG_CAP_RISE: next_prdata = widen(cap_rise); // [R18] [R19]
			`PTC_REG_CAP_FALL: next_prdata = widen(cap_fall); // [R18] [R19]
			`PTC_REG_STATUS: begin
				next_prdata[0] = (state == ptc_pkg::ST_RUN);
				next_prdata[1] = (state == ptc_pkg::ST_CAPTURE);
				next_prdata[2] = repeat_run;
				next_prdata[3] = counter_mode;
				next_prdata[4] = o_timer_out;
			end
			default:           next_prdata = '0;
		endcase
	end

	// The slave answers in the first access cycle: ready and data are set up a cycle early.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
		end else begin
			o_pready  <= apb_setup;
			o_pslverr <= apb_setup && !addr_known;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			o_prdata <= '0;
		else if (apb_setup && !i_apb.pwrite)
			o_prdata <= next_prdata;
	end

	// Configuration and compare registers.

	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			cfg <= ptc_pkg::cfg_t'(`PTC_CFG_RST);
		else if (apb_write && i_apb.paddr == `PTC_REG_CFG) begin
			cfg <= ptc_pkg::cfg_t'(i_apb.pwdata[`PTC_CFG_W-1:0]);
			if (i_apb.pwdata[`PTC_PRESC_W-1:0] > `PTC_PRESC_MAX)
				cfg.prescale_index <= `PTC_PRESC_MAX; // [R20]
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			rise_compare_wide   <= `PTC_CMP_RST;
			period_compare_wide <= `PTC_CMP_RST;
		end else if (apb_write) begin
			if (i_apb.paddr == `PTC_REG_RISE)
				rise_compare_wide <= i_apb.pwdata[CMP_W-1:0];
			if (i_apb.paddr == `PTC_REG_PERIOD)
				period_compare_wide <= i_apb.pwdata[CMP_W-1:0];
		end
	end

	assign rise_eff   = fit_width(rise_compare_wide, cfg.clk32_sel); // [R14]
	assign period_eff = fit_width(period_compare_wide, cfg.clk32_sel); // [R14]

	// Commands.

	assign start_single  = cmd_write && i_apb.pwdata[`PTC_CMD_SINGLE];
	assign start_repeat  = cmd_write && i_apb.pwdata[`PTC_CMD_REPEAT];
	assign start_capture = cmd_write && i_apb.pwdata[`PTC_CMD_CAPTURE] && HAS_INPUTS; // [R15]
	assign stop_cmd      = cmd_write && i_apb.pwdata[`PTC_CMD_STOP];
	assign any_start     = !stop_cmd && (start_single || start_repeat || start_capture);

	// Input pins are asynchronous, so each passes two flip-flops first.

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			cap_meta <= 1'b0;
			cap_sync <= 1'b0;
			cnt_meta <= 1'b0;
			cnt_sync <= 1'b0;
		end else begin
			cap_meta <= i_capture_pin;
			cap_sync <= cap_meta;
			cnt_meta <= i_count_pin;
			cnt_sync <= cnt_meta;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			cnt_prev <= 1'b0;
		else
			cnt_prev <= cnt_sync;
	end

	// Builds without inputs see a constant low level, so input settings have no effect.
	assign cap_level = HAS_INPUTS ? (cap_sync ^ cfg.capture_invert) : 1'b0; // [R2] [R4]

	always_comb begin
		edge_event = 1'b0;
		if (HAS_INPUTS) begin // [R4]
			if (cnt_sync && !cnt_prev)
				edge_event = 1'b1; // [R3]
			else if (!cnt_sync && cnt_prev && cfg.count_both_edges)
				edge_event = 1'b1; // [R3]
		end
	end

	// Tick generation.

	assign src_tick = cfg.clk32_sel ? i_src32_tick : i_src16_tick;

	tick_divider #(
		.IDX_W (`PTC_PRESC_W),
		.DIV_W (`PTC_DIV_W)
	) u_divider (
		.i_clk      (i_clk),
		.i_sys_rst  (i_sys_rst),
		.i_restart  (any_start),
		.i_src_tick (src_tick),
		.i_index    (cfg.prescale_index),
		.o_tick     (timer_tick)
	); // [R20]

	assign run_event  = counter_mode ? edge_event : timer_tick;
	assign next_count = fit_width(count + CMP_W'(1), cfg.clk32_sel);
	assign cap_now    = cap_level;

	// Mode state.

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			state        <= ptc_pkg::ST_IDLE;
			repeat_run   <= 1'b0;
			counter_mode <= 1'b0;
		end else if (stop_cmd) begin
			state        <= ptc_pkg::ST_IDLE;
			repeat_run   <= 1'b0;
		end else if (start_capture) begin
			state        <= ptc_pkg::ST_CAPTURE;
			repeat_run   <= 1'b0;
			counter_mode <= 1'b0;
		end else if (start_single || start_repeat) begin
			state        <= ptc_pkg::ST_RUN;
			repeat_run   <= start_repeat; // [R11]
			counter_mode <= HAS_INPUTS && cfg.ext_count; // [R10]
		end else begin
			case (state)
				ptc_pkg::ST_IDLE:    state <= ptc_pkg::ST_IDLE;
				ptc_pkg::ST_RUN: begin
					if (run_event && next_count == period_eff && !repeat_run)
						state <= ptc_pkg::ST_IDLE; // [R7] [R9]
				end
				ptc_pkg::ST_CAPTURE: state <= ptc_pkg::ST_CAPTURE;
				default:             state <= ptc_pkg::ST_IDLE;
			endcase
		end
	end

	// Count, shared by timer, counter and capture modes.

	always_ff @(posedge i_clk) begin
		if (i_sys_rst || any_start)
			count <= '0;
		else if (state == ptc_pkg::ST_RUN && run_event) begin
			if (next_count == period_eff && repeat_run)
				count <= '0; // [R11] [R12]
			else
				count <= next_count;
		end else if (state == ptc_pkg::ST_CAPTURE && timer_tick)
			count <= next_count;
	end

	// Pulse output and interrupt strobes.

	always_ff @(posedge i_clk) begin
		if (i_sys_rst || any_start || stop_cmd)
			o_timer_out <= 1'b0; // [R6]
		else if (state == ptc_pkg::ST_RUN && run_event) begin
			if (next_count == period_eff)
				o_timer_out <= 1'b0; // [R7]
			else if (next_count == rise_eff)
				o_timer_out <= 1'b1; // [R6]
		end
	end

	// Period is checked first so a misprogrammed equal pair still ends the cycle.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_rise_interrupt   <= 1'b0;
			o_period_interrupt <= 1'b0;
		end else begin
			o_rise_interrupt   <= 1'b0;
			o_period_interrupt <= 1'b0;
			if (state == ptc_pkg::ST_RUN && run_event && !stop_cmd && !any_start) begin
				if (next_count == period_eff)
					o_period_interrupt <= cfg.period_irq_enable; // [R8] [R9] [R12] [R21]
				else if (next_count == rise_eff)
					o_rise_interrupt <= cfg.rise_irq_enable; // [R8] [R9] [R21]
			end
		end
	end

	// Capture.

	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			cap_sample <= 1'b0;
		else if (start_capture)
			cap_sample <= cap_now;
		else if (state == ptc_pkg::ST_CAPTURE && timer_tick)
			cap_sample <= cap_now; // [R1]
	end

	// Results change only on a newer edge or a capture start, which clears them, so they wait for software.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			cap_rise <= '0;
			cap_fall <= '0;
		end else if (start_capture) begin
			cap_rise <= '0;
			cap_fall <= '0;
		end else if (state == ptc_pkg::ST_CAPTURE && timer_tick) begin
			if (cap_now && !cap_sample)
				cap_rise <= next_count; // [R17] [R19]
			if (!cap_now && cap_sample)
				cap_fall <= next_count; // [R17] [R19]
		end
	end

endmodule

// ### shared/ptc_defs.svh
// Register map, field positions, reset values and limits of the pulse timer channel.
// Functional notes
// [R1] Capture mode samples the capture input once on every timer tick.
// [R2] Capture invert flips the capture input so low pulses are timed.
// [R3] Counter mode counts rising edges, or both edges when count_both_edges is set.
// [R4] Only the timer 0 build has external inputs; others ignore input settings.
// [R5] Software sets invert and edge options after enable, before start.
// [R6] Single shot: output low until rise compare ticks elapse, then high.
// [R7] Output stays high until period compare ticks since start, then low.
// [R8] Rise and period interrupts fire on output edges when enabled.
// [R9] Single-shot counter: rise irq at rise compare, period irq at period, stop.
// [R10] Counter mode exists on timer 0 only.
// [R11] Repeat start reruns the low-then-high cycle until stopped.
// [R12] Repeat counter: period irq at period compare, then count restarts at zero.
// [R13] The running count is readable at any time without disturbing it.
// [R14] Compares are 16 bits on the 16 MHz source, 17 bits on 32 MHz.
// [R15] Capture mode exists on timer 0 only.
// [R16] Software sets capture options before starting capture.
// [R17] Capture records tick counts of the latest rising and falling input edges.
// [R18] Capture results stay in readable registers until fetched.
// [R19] On the 32 MHz source capture results are 17 bits wide.
// [R20] The timer tick is the source clock divided by two to the prescale index.
// [R21] Rise and period interrupts have separate enables.
// [R22] Software should keep rise compare below period compare.
`ifndef PTC_DEFS_SVH
`define PTC_DEFS_SVH

`define PTC_REG_CFG        8'h00
`define PTC_REG_CMD        8'h04
`define PTC_REG_RISE       8'h08
`define PTC_REG_PERIOD     8'h0c
`define PTC_REG_COUNT      8'h10
`define PTC_REG_CAP_RISE   8'h14
`define PTC_REG_CAP_FALL   8'h18
`define PTC_REG_STATUS     8'h1c

`define PTC_CFG_W          11
`define PTC_CMD_SINGLE     0
`define PTC_CMD_REPEAT     1
`define PTC_CMD_CAPTURE    2
`define PTC_CMD_STOP       3

`define PTC_CMP_W          17
`define PTC_NARROW_W       16
`define PTC_PRESC_W        5
`define PTC_PRESC_MAX      5'h10
`define PTC_DIV_W          16

`define PTC_CFG_RST        11'h000
`define PTC_CMP_RST        17'h00000

`endif

// ### shared/ptc_pkg.sv
// Types shared by the pulse timer channel and its bench.
package ptc_pkg;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic       ext_count;
		logic       clk32_sel;
		logic       count_both_edges;
		logic       capture_invert;
		logic       period_irq_enable;
		logic       rise_irq_enable;
		logic [4:0] prescale_index;
	} cfg_t;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b001,
		ST_RUN     = 3'b010,
		ST_CAPTURE = 3'b100
	} state_t;

endpackage

// ### hdl/tick_divider.sv
// Power-of-two divider that turns source clock strobes into timer ticks.
module tick_divider #(
	parameter int IDX_W = 5,
	parameter int DIV_W = 16
) (
	input  wire logic             i_clk,
	input  wire logic             i_sys_rst,
	input  wire logic             i_restart,
	input  wire logic             i_src_tick,
	input  wire logic [IDX_W-1:0] i_index,
	output logic                  o_tick
);

	logic [DIV_W-1:0] div_count;
	logic [DIV_W-1:0] div_mask;

	always_comb begin
		div_mask = '0;
		for (int i = 0; i < DIV_W; i++) begin
			if (i < int'(i_index))
				div_mask[i] = 1'b1;
		end
	end

	// Restarting on every start keeps the first tick a full divided period away.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || i_restart)
			div_count <= '0;
		else if (i_src_tick)
			div_count <= div_count + DIV_W'(1);
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst || i_restart)
			o_tick <= 1'b0;
		else
			o_tick <= i_src_tick && ((div_count & div_mask) == div_mask); // [R20]
	end

endmodule

// ### verif/ptc_monitor.sv
// Port assertions for the pulse timer channel.
module ptc_monitor #(
	parameter bit HAS_INPUTS = 1'b1,
	parameter int CMP_W      = 17
) (
	input  wire logic        i_clk,
	input  wire logic        i_sys_rst,
	input  ptc_pkg::apb_req_t i_apb,
	input  wire logic        o_pready,
	input  wire logic [31:0] o_prdata,
	input  wire logic        o_pslverr,
	input  wire logic        o_timer_out,
	input  wire logic        o_rise_interrupt,
	input  wire logic        o_period_interrupt
);
	logic cnt;
	logic cfg_wr;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	assign cfg_wr = i_apb.psel && i_apb.penable && o_pready && i_apb.pwrite;
	// Counter mode ties interrupts to pin edges, so output edge checks skip it.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			cnt <= 1'b0;
		end else if (cfg_wr && i_apb.paddr == 8'h00) begin
			cnt <= i_apb.pwdata[10];
		end
	end
	a_pready_next: assert property (i_apb.psel && !i_apb.penable |=> o_pready)
		else $error("pready late");
	a_pready_once: assert property (o_pready |=> !o_pready)
		else $error("pready held");
	a_unmapped_zero: assert property (o_pslverr && !i_apb.pwrite |-> o_pready && o_prdata == 32'h0)
		else $error("bad error read");
	a_cmd_reads_zero: assert property (o_pready && !i_apb.pwrite && i_apb.paddr == 8'h04
		|-> o_prdata == 32'h0) else $error("command read not zero");
	a_rise_edge: assert property (!cnt && o_rise_interrupt |-> $rose(o_timer_out))
		else $error("rise irq without rising output");
	a_period_edge: assert property (!cnt && o_period_interrupt |-> $fell(o_timer_out))
		else $error("period irq without falling output");
	a_rise_pulse: assert property (o_rise_interrupt |=> !o_rise_interrupt)
		else $error("rise irq too long");
	a_period_pulse: assert property (o_period_interrupt |=> !o_period_interrupt)
		else $error("period irq too long");
	a_irq_apart: assert property (o_rise_interrupt |-> !o_period_interrupt)
		else $error("both irqs at once");
endmodule

bind pulse_timer_counter_capture ptc_monitor #(
	.HAS_INPUTS(HAS_INPUTS),
	.CMP_W     (CMP_W)
) i_mon (
	.i_clk             (i_clk),
	.i_sys_rst         (i_sys_rst),
	.i_apb             (i_apb),
	.o_pready          (o_pready),
	.o_prdata          (o_prdata),
	.o_pslverr         (o_pslverr),
	.o_timer_out       (o_timer_out),
	.o_rise_interrupt  (o_rise_interrupt),
	.o_period_interrupt(o_period_interrupt)
);

// ### verif/pin_source.sv
// Model of the external source that drives the capture and count pins.
module pin_source (
	input  wire logic i_clk,
	output logic      o_capture_pin,
	output logic      o_count_pin
);
	timeunit 1ns;
	timeprecision 100ps;
	int n_edges = 0;
	initial begin
		o_capture_pin = 1'b0;
		o_count_pin = 1'b0;
	end
	task automatic set_cap(input logic v);
		o_capture_pin <= v;
	endtask
	// Levels last 12 cycles so the two-flop synchroniser never misses one.
	task automatic toggle(input int n);
		repeat (n) begin
			@(posedge i_clk);
			o_count_pin <= !o_count_pin;
			n_edges++;
			repeat (11) @(posedge i_clk);
		end
	endtask
endmodule

// ### verif/tb_top.sv
// Self-checking bench for the pulse timer channel.
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic i_clk, rst, src_en, s16, s32, pin_c, pin_n;
	logic rdy, err, tout, irq_r, irq_p;
	logic [31:0] rdata;
	logic [1:0] cyc = 2'h0;
	logic [23:0] ev;
	ptc_pkg::apb_req_t bus;
	logic [32:0] exp_rd[$];
	logic [23:0] exp_ev[$];
	int n_fail = 0, n_checks = 0, n_str = 0, tmo = 0, seed = 32'h0992a229, r, p, sh;
	bit cnt_mode = 0;
	pulse_timer_counter_capture i_dut (.i_clk(i_clk), .i_sys_rst(rst), .i_apb(bus),
		.o_pready(rdy), .o_prdata(rdata), .o_pslverr(err), .i_src16_tick(s16),
		.i_src32_tick(s32), .i_capture_pin(pin_c), .i_count_pin(pin_n),
		.o_timer_out(tout), .o_rise_interrupt(irq_r), .o_period_interrupt(irq_p));
	pin_source i_src (.i_clk(i_clk), .o_capture_pin(pin_c), .o_count_pin(pin_n));
	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end
	// Strobes pause around a start so tick counts begin exactly at the start edge.
	always @(posedge i_clk) begin
		cyc <= cyc + 2'h1;
		s16 <= src_en && cyc == 2'h3;
		s32 <= src_en && cyc[0];
		tmo++;
		if (tmo == 20000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask
	always @(posedge i_clk) begin
		if (s16) n_str++;
		ev = {irq_r, irq_p, 2'b00, 20'(cnt_mode ? i_src.n_edges : n_str)};
		if (!rst && (irq_r || irq_p)) check(ev, exp_ev.size() ? exp_ev.pop_front() : 24'h0);
		if (bus.psel && bus.penable && rdy && !bus.pwrite) check({err, rdata}, exp_rd.pop_front());
	end
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
		int t;
		if (!wr) exp_rd.push_back(e);
		bus <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge i_clk);
		bus.penable <= 1'b1;
		t = 0;
		do begin
			@(posedge i_clk);
			t++;
		end while (rdy !== 1'b1 && t < 50);
		// A slave that never answers counts as a failure instead of passing silently.
		if (t >= 50) n_fail++;
		bus <= '0;
		@(posedge i_clk);
	endtask
	task automatic start(input logic [31:0] cmd);
		src_en <= 1'b0;
		@(posedge i_clk);
		apb(1'b1, 8'h04, cmd, 33'h0);
		n_str = 0;
		src_en <= 1'b1;
	endtask
	task automatic wait_ev();
		int t;
		t = 0;
		while (exp_ev.size() > 0 && t < 4000) begin
			@(posedge i_clk);
			t++;
		end
	endtask
	task automatic tally_and_finish();
		check(64'(exp_ev.size() + exp_rd.size()), 64'h0);
		$display("checks=%0d fails=%0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		rst = 1'b1;
		bus = '0;
		src_en = 1'b0;
		repeat (10) @(posedge i_clk);
		rst <= 1'b0;
		@(posedge i_clk);
		apb(1'b0, 8'h00, 32'h0, 33'h0);
		apb(1'b0, 8'h24, 32'h0, 33'h100000000);
		apb(1'b1, 8'h00, 32'h1f, 33'h0);
		apb(1'b0, 8'h00, 32'h0, 33'h10);
		apb(1'b0, 8'h04, 32'h0, 33'h0);
		for (int i = 0; i < 4; i++) begin
			r = 2 + $unsigned($random(seed)) % 4;
			p = r + 2 + $unsigned($random(seed)) % 4;
			sh = i % 2;
			apb(1'b1, 8'h00, (i == 3 ? 32'h40 : 32'h60) | sh, 33'h0);
			apb(1'b1, 8'h08, r, 33'h0);
			apb(1'b1, 8'h0c, p, 33'h0);
			for (int k = 0; k < (i > 1 ? 2 : 1); k++) begin
				if (i != 3) exp_ev.push_back({4'h8, 20'((k * p + r) << sh)});
				exp_ev.push_back({4'h4, 20'(((k + 1) * p) << sh)});
			end
			start(i > 1 ? 32'h2 : 32'h1);
			wait_ev();
			if (i == 0) apb(1'b0, 8'h10, 32'h0, 33'(p));
			apb(1'b1, 8'h04, 32'h8, 33'h0);
		end
		cnt_mode = 1;
		apb(1'b1, 8'h00, 32'h560, 33'h0);
		apb(1'b1, 8'h08, 32'h3, 33'h0);
		apb(1'b1, 8'h0c, 32'h6, 33'h0);
		exp_ev.push_back({4'h8, 20'd3});
		exp_ev.push_back({4'h4, 20'd6});
		start(32'h1);
		i_src.toggle(8);
		apb(1'b0, 8'h10, 32'h0, 33'd6);
		// Rising edges only, repeating: odd toggles count, period restarts the count.
		apb(1'b1, 8'h00, 32'h460, 33'h0);
		apb(1'b1, 8'h08, 32'h2, 33'h0);
		apb(1'b1, 8'h0c, 32'h3, 33'h0);
		i_src.n_edges = 0;
		exp_ev.push_back({4'h8, 20'd3});
		exp_ev.push_back({4'h4, 20'd5});
		start(32'h2);
		i_src.toggle(8);
		apb(1'b0, 8'h10, 32'h0, 33'd1);
		apb(1'b1, 8'h04, 32'h8, 33'h0);
		cnt_mode = 0;
		apb(1'b1, 8'h00, 32'h80, 33'h0);
		start(32'h4);
		repeat (5) @(posedge i_clk iff s16);
		i_src.set_cap(1'b1);
		repeat (10) @(posedge i_clk iff s16);
		i_src.set_cap(1'b0);
		repeat (5) @(posedge i_clk iff s16);
		apb(1'b0, 8'h14, 32'h0, 33'd16);
		apb(1'b0, 8'h18, 32'h0, 33'd6);
		apb(1'b1, 8'h04, 32'h8, 33'h0);
		apb(1'b0, 8'h14, 32'h0, 33'd16);
		tally_and_finish();
	end
endmodule
